// ==== design/wic_cfg.svh ====
// Constants for the wake input control block: offsets, fields, resets, timing.
// Assumes a 10 MHz system clock and an APB slave with 32-bit data.
`ifndef WIC_CFG_SVH
`define WIC_CFG_SVH

// --------------------------------------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------------------------------------
`define WIC_OFS_BIAS 12'h000
`define WIC_OFS_SRC 12'h004
`define WIC_OFS_MEAS 12'h008
`define WIC_OFS_EVT 12'h00C
`define WIC_OFS_LVL 12'h010
`define WIC_OFS_MASK 12'h014
`define WIC_OFS_MODE 12'h018

// --------------------------------------------------------------------------
// Field encodings and resets
// --------------------------------------------------------------------------
`define WIC_BIAS_NONE 2'h0
`define WIC_BIAS_DOWN 2'h1
`define WIC_BIAS_UP 2'h2
`define WIC_BIAS_AUTO 2'h3
`define WIC_SRC_WAKE_EN 0
`define WIC_SRC_CYCLIC 1
`define WIC_SRC_OTHER 2
`define WIC_MEAS_EN 0
`define WIC_MEAS_FO_TEST 1
`define WIC_EVT_PIN 0
`define WIC_EVT_CMD_FAIL 1
`define WIC_MODE_SLEEP_REQ 0

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define WIC_CLK_HZ 10000000
`define WIC_FILT_TIME_US 16
`define WIC_FILT_CYC ((`WIC_FILT_TIME_US * `WIC_CLK_HZ) / 1000000)

`endif

// ==== design/wic_pkg.sv ====
// Types for the wake input control block.
// Assumes wic_cfg.svh supplies all numeric constants.
package wic_pkg;
  typedef enum logic [1:0] {
    WIC_MODE_NORMAL,
    WIC_MODE_STOP,
    WIC_MODE_SLEEP,
    WIC_MODE_RESTART
  } wic_mode_e;
  typedef logic [31:0] wic_word_t;
  typedef logic [7:0] wic_cnt_t;
endpackage

// ==== design/wic_wake_ctrl.sv ====
// Wake input control: bias select, filter, cyclic sense, measurement gating.
// Assumes synchronous comparator level, APB master, 10 MHz clock.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "wic_cfg.svh"

// How it works
// R1 - Bias code 00 enables no current source; reset value.
// R2 - Bias code 01 enables only the pull-down source.
// R3 - Bias code 10 enables only the pull-up source.
// R4 - Bias code 11 follows detected level: high pull-up, low pull-down.
// R5 - Cyclic sense samples only while timer high-side switch is on.
// R6 - Software must set the general purpose pin as timer high-side switch.
// R7 - Measurement enable disables fail output, its test, GPIO and wake.
// R8 - Measurement enable turns off both sources and blocks wake signal.
// R9 - Measurement enable ignores wake settings, yet writes still land.
// R10 - Measurement enable blocks the pin event bit and clears level status.
// R11 - Sleep request with measurement and pin-only wake: fail flag, restart.
// R12 - Wake filter nominal 16 us, from the internal clock.
// R13 - Each crossing restarts the filter; level accepted when it expires.
// R14 - Both edges are wake events: interrupt awake, wake-up asleep.
// R15 - Pin wake sets event bit; present level shows in level status.
// R16 - Automatic mode chooses source from the accepted filtered level.
// R17 - Bias changes reach the source enables two cycles after the write.
module wic_wake_ctrl (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire wic_pkg::wic_word_t pwdata_in,
  output wic_pkg::wic_word_t prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Wake pin and timer switch
  input wire logic wake_input_in,
  input wire logic high_side_switch_on_in,
  // Device mode
  input wire wic_pkg::wic_mode_e mode_in,
  // Outputs to analog and system
  output logic pull_up_en_out,
  output logic pull_down_en_out,
  output logic wake_signal_out,
  output logic fail_output_en_out,
  output logic gpio_en_out,
  output logic fail_out_test_on_out,
  output logic wake_up_req_out,
  output logic restart_req_out,
  output logic irq_out
);
  import wic_pkg::*;

  // ------------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] wake_bias_select;
    logic [2:0] wake_source_control;
    logic [1:0] meas;
    logic [1:0] wake_event_status;
    logic [1:0] mask;
    logic wake_level_status;
    logic filt_level;
    logic raw_prev;
    wic_cnt_t filt_cnt;
    logic cyc_level;
    logic cyc_valid;
    logic pull_up;
    logic pull_down;
    logic wake_up_req;
    logic restart_req;
    wic_word_t rdata;
  } wic_state_s;

  wic_state_s state_reg;
  wic_state_s state_next;

  logic meas_on;
  logic apb_wr;
  logic apb_rd;
  logic gated_in;
  logic accept;
  logic sample;
  logic pin_event;
  logic asleep;
  wic_word_t rd_mux;

  always_comb begin
    meas_on = state_reg.meas[`WIC_MEAS_EN];
    apb_wr = psel_in && penable_in && pwrite_in;
    apb_rd = psel_in && !penable_in && !pwrite_in;
    // Measurement blocks the internal wake path entirely
    gated_in = wake_input_in && !meas_on; // [R8]
    asleep = (mode_in == WIC_MODE_SLEEP);
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `WIC_OFS_BIAS: rd_mux = {30'h0, state_reg.wake_bias_select};
      `WIC_OFS_SRC: rd_mux = {29'h0, state_reg.wake_source_control};
      `WIC_OFS_MEAS: rd_mux = {30'h0, state_reg.meas};
      `WIC_OFS_EVT: rd_mux = {30'h0, state_reg.wake_event_status};
      `WIC_OFS_LVL: rd_mux = {31'h0, state_reg.wake_level_status};
      `WIC_OFS_MASK: rd_mux = {30'h0, state_reg.mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.wake_up_req = 1'b0;
    state_next.restart_req = 1'b0;
    accept = 1'b0;
    sample = 1'b0;
    pin_event = 1'b0;

    // Static filter: any crossing restarts the interval
    state_next.raw_prev = gated_in;
    if (gated_in != state_reg.raw_prev) begin
      state_next.filt_cnt = 8'h00; // [R13]
    end else if (state_reg.filt_cnt < 8'(`WIC_FILT_CYC)) begin
      state_next.filt_cnt = state_reg.filt_cnt + 8'h01; // [R12]
    end
    if (state_reg.filt_cnt == 8'(`WIC_FILT_CYC - 1) && gated_in == state_reg.raw_prev
        && state_reg.raw_prev != state_reg.filt_level) begin
      accept = 1'b1; // [R13]
      state_next.filt_level = state_reg.raw_prev;
    end

    // Cyclic sense takes the level only during switch on-time
    if (state_reg.wake_source_control[`WIC_SRC_CYCLIC]) begin
      sample = high_side_switch_on_in && !meas_on; // [R5]
      if (sample) begin
        state_next.cyc_valid = 1'b1;
        state_next.cyc_level = gated_in;
        pin_event = state_reg.cyc_valid && (gated_in != state_reg.cyc_level); // [R5]
      end
    end else begin
      state_next.cyc_valid = 1'b0;
      pin_event = accept; // [R14]
    end

    // Level status forced low while measuring; otherwise live or cyclic-sampled level
    if (meas_on) begin
      state_next.wake_level_status = 1'b0; // [R10]
    end else begin
      state_next.wake_level_status = state_reg.wake_source_control[`WIC_SRC_CYCLIC] ?
                                     state_next.cyc_level : gated_in; // [R15]
    end

    // Bias selection, ignored while measuring
    state_next.pull_up = 1'b0;
    state_next.pull_down = 1'b0;
    if (!meas_on) begin // [R9]
      case (state_reg.wake_bias_select)
        `WIC_BIAS_NONE: state_next.pull_up = 1'b0; // [R1]
        `WIC_BIAS_DOWN: state_next.pull_down = 1'b1; // [R2]
        `WIC_BIAS_UP: state_next.pull_up = 1'b1; // [R3]
        `WIC_BIAS_AUTO: begin
          // Filtered level avoids toggling on noise
          state_next.pull_up = state_reg.filt_level; // [R4] [R16]
          state_next.pull_down = !state_reg.filt_level; // [R4] [R16]
        end
        default: state_next.pull_up = 1'b0;
      endcase
    end

    // Register writes; settings accepted even while measuring
    if (apb_wr) begin
      case (paddr_in)
        `WIC_OFS_BIAS: state_next.wake_bias_select = pwdata_in[1:0]; // [R9] [R17]
        `WIC_OFS_SRC: state_next.wake_source_control = pwdata_in[2:0]; // [R9]
        `WIC_OFS_MEAS: state_next.meas = pwdata_in[1:0];
        `WIC_OFS_EVT: state_next.wake_event_status = state_reg.wake_event_status
                                                     & ~pwdata_in[1:0];
        `WIC_OFS_MASK: state_next.mask = pwdata_in[1:0];
        `WIC_OFS_MODE: begin
          // Pin is the only wake source but it is blocked
          if (pwdata_in[`WIC_MODE_SLEEP_REQ] && meas_on
              && state_reg.wake_source_control[`WIC_SRC_WAKE_EN]
              && !state_reg.wake_source_control[`WIC_SRC_OTHER]) begin
            state_next.wake_event_status[`WIC_EVT_CMD_FAIL] = 1'b1; // [R11]
            state_next.restart_req = 1'b1; // [R11]
          end
        end
        default: state_next.mask = state_reg.mask;
      endcase
    end

    // Event set wins over a same-cycle clear
    if (pin_event && !meas_on && state_reg.wake_source_control[`WIC_SRC_WAKE_EN]) begin
      state_next.wake_event_status[`WIC_EVT_PIN] = 1'b1; // [R10] [R15]
      state_next.wake_up_req = asleep; // [R14]
    end

    state_next.rdata = apb_rd ? rd_mux : state_reg.rdata;
  end

  // ------------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= '0; // [R1]
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------------
  assign prdata_out = state_reg.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign pull_up_en_out = state_reg.pull_up;
  assign pull_down_en_out = state_reg.pull_down;
  assign wake_signal_out = state_reg.filt_level;
  assign fail_output_en_out = !state_reg.meas[`WIC_MEAS_EN]; // [R7]
  assign gpio_en_out = !state_reg.meas[`WIC_MEAS_EN]; // [R7]
  assign fail_out_test_on_out = state_reg.meas[`WIC_MEAS_FO_TEST]
                                && !state_reg.meas[`WIC_MEAS_EN]; // [R7]
  assign wake_up_req_out = state_reg.wake_up_req;
  assign restart_req_out = state_reg.restart_req;
  // Interrupt only in awake modes
  assign irq_out = |(state_reg.wake_event_status & state_reg.mask)
                   && (mode_in == WIC_MODE_NORMAL || mode_in == WIC_MODE_STOP); // [R14]
endmodule

// ==== verification/wake_input_control_tb.sv ====
// Testbench for wic_wake_ctrl: APB master tasks, pin model, checker.
// Assumes wic_cfg.svh on the include path.
`timescale 1ns/10ps
`include "wic_cfg.svh"
module wake_input_control_tb;
  import wic_pkg::*;
  typedef struct packed {logic [1:0] code; logic open; logic lvl; logic [1:0] src;} wic_row_s;
  wic_row_s rows [5] = '{6'h00, 6'h19, 6'h2A, 6'h36, 6'h31};
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, high_side_switch_on_in = 1'b0, open_pin = 1'b0, lvl = 1'b0;
  logic wake_input_in, pready_out, pslverr_out, pull_up_en_out, pull_down_en_out;
  logic wake_signal_out, fail_output_en_out, gpio_en_out, fail_out_test_on_out;
  logic wake_up_req_out, restart_req_out, irq_out;
  logic [11:0] paddr_in = 12'h000;
  wic_word_t pwdata_in = 32'h0, prdata_out, rdata;
  wic_mode_e mode_in = WIC_MODE_NORMAL;
  int fails = 0, check_count = 0;
  wire [5:0] st = {irq_out, fail_output_en_out, gpio_en_out, fail_out_test_on_out,
    pull_up_en_out, pull_down_en_out};
  wic_wake_ctrl wic_wake_ctrl_inst (.*);
  wic_pin_model wic_pin_model_inst (.ref_clk_in, .open_in(open_pin), .level_in(lvl),
    .pull_up_en_in(pull_up_en_out), .pull_down_en_in(pull_down_en_out), .pin_out(wake_input_in));
  task automatic cyc(input int n); repeat (n) @(posedge ref_clk_in); endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input wic_word_t d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in) penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rdata = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input wic_word_t d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [11:0] a, input wic_word_t e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
    chk({pready_out, pslverr_out}, 32'h2);
  endtask
  task automatic wait_hi(input logic sel);
    int n;
    n = 0;
    while ((sel ? restart_req_out : wake_up_req_out) !== 1'b1 && n < 300) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(n < 300, 32'h1);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial forever #50 ref_clk_in = ~ref_clk_in;
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    chk(st, 32'h18);
    foreach (rows[i]) begin
      open_pin <= rows[i].open;
      lvl <= rows[i].lvl;
      cyc(200);
      wr(`WIC_OFS_BIAS, {30'h0, rows[i].code});
      cyc(2);
      chk(st, {26'h0, 4'h6, rows[i].src});
      rd(`WIC_OFS_BIAS, {30'h0, rows[i].code});
    end
    wr(`WIC_OFS_SRC, 32'h1);
    wr(`WIC_OFS_MASK, 32'h1);
    lvl <= 1'b1;
    cyc(100);
    lvl <= 1'b0;
    cyc(200);
    rd(`WIC_OFS_EVT, 32'h0);
    lvl <= 1'b1;
    cyc(200);
    rd(`WIC_OFS_EVT, 32'h1);
    rd(`WIC_OFS_LVL, 32'h1);
    chk(wake_signal_out, 32'h1);
    chk(irq_out, 32'h1);
    wr(`WIC_OFS_MASK, 32'h0);
    chk(irq_out, 32'h0);
    wr(`WIC_OFS_MASK, 32'h1);
    wr(`WIC_OFS_EVT, 32'h1);
    chk(irq_out, 32'h0);
    rd(12'h01C, 32'h0);
    mode_in <= WIC_MODE_SLEEP;
    lvl <= 1'b0;
    wait_hi(1'b0);
    mode_in <= WIC_MODE_NORMAL;
    lvl <= 1'b1;
    cyc(200);
    wr(`WIC_OFS_EVT, 32'h3);
    wr(`WIC_OFS_MEAS, 32'h3);
    cyc(3);
    chk(st, 32'h0);
    rd(`WIC_OFS_LVL, 32'h0);
    lvl <= 1'b0;
    cyc(200);
    rd(`WIC_OFS_EVT, 32'h0);
    chk(wake_signal_out, 32'h0);
    wr(`WIC_OFS_BIAS, 32'h1);
    rd(`WIC_OFS_BIAS, 32'h1);
    wr(`WIC_OFS_MODE, 32'h1);
    wait_hi(1'b1);
    rd(`WIC_OFS_EVT, 32'h2);
    wr(`WIC_OFS_EVT, 32'h3);
    wr(`WIC_OFS_MEAS, 32'h2);
    cyc(2);
    chk(st, 32'h1D);
    wr(`WIC_OFS_SRC, 32'h3);
    wr(`WIC_OFS_EVT, 32'h3);
    high_side_switch_on_in <= 1'b1;
    cyc(1);
    high_side_switch_on_in <= 1'b0;
    lvl <= 1'b1;
    cyc(200);
    rd(`WIC_OFS_EVT, 32'h0);
    high_side_switch_on_in <= 1'b1;
    cyc(1);
    high_side_switch_on_in <= 1'b0;
    cyc(3);
    rd(`WIC_OFS_EVT, 32'h1);
    sys_rst_in <= 1'b1;
    cyc(2);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    chk(st, 32'h18);
    rd(`WIC_OFS_BIAS, 32'h0);
    tally_and_finish();
  end
endmodule
bind wic_wake_ctrl wic_checker wic_checker_inst (.*);

// ==== verification/wic_checker.sv ====
// Port checker for wic_wake_ctrl.
// Assumes a bind by port name and one clock.
`timescale 1ns/10ps
module wic_checker (
  input wire logic ref_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire wic_pkg::wic_word_t pwdata_in,
  input wire wic_pkg::wic_mode_e mode_in,
  input wire logic wake_input_in, pull_up_en_out, pull_down_en_out, wake_signal_out,
  input wire logic fail_output_en_out, gpio_en_out, fail_out_test_on_out,
  input wire logic wake_up_req_out, restart_req_out
);
  import wic_pkg::*;
  logic last_reg;
  wic_cnt_t stab_reg;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Saturating run length, so long idle stretches stay valid
  always_ff @(posedge ref_clk_in) begin
    last_reg <= wake_input_in;
    if (sys_rst_in || wake_input_in != last_reg) stab_reg <= 8'h00;
    else if (stab_reg != 8'hFF) stab_reg <= stab_reg + 8'h01;
  end
  a_src_exclusive: assert property (!(pull_up_en_out && pull_down_en_out))
    else $error("both sources on");
  a_bias_apply: assert property (psel_in && penable_in && pwrite_in && paddr_in == 12'h000
    && (pwdata_in[1] ^ pwdata_in[0]) && fail_output_en_out |=> ##1
    {pull_up_en_out, pull_down_en_out} == $past(pwdata_in[1:0], 2)) else $error("bias late");
  a_meas_sources: assert property (!fail_output_en_out [*3] |->
    !pull_up_en_out && !pull_down_en_out) else $error("source on while measuring");
  a_meas_gpio: assert property (fail_output_en_out == gpio_en_out)
    else $error("gpio and fail output disagree");
  a_meas_test: assert property (fail_out_test_on_out |-> fail_output_en_out)
    else $error("test on while measuring");
  a_wake_sleep: assert property (wake_up_req_out |-> $past(mode_in) == WIC_MODE_SLEEP)
    else $error("wake request outside sleep");
  a_restart_pulse: assert property (restart_req_out |=> !restart_req_out)
    else $error("restart not a pulse");
  a_filter_hold: assert property ($changed(wake_signal_out) && fail_output_en_out
    && $past(fail_output_en_out) |-> stab_reg >= 8'h96 && wake_signal_out == last_reg)
    else $error("level accepted early");
endmodule

// ==== verification/wic_pin_model.sv ====
// Wake pin model: driven level, or open pin held by the bias sources.
// Assumes source enables from the device; an unbiased open pin floats.
`timescale 1ns/10ps
module wic_pin_model (
  input wire logic ref_clk_in,
  input wire logic open_in,
  input wire logic level_in,
  input wire logic pull_up_en_in,
  input wire logic pull_down_en_in,
  output logic pin_out
);
  logic float_reg = 1'b0;
  // Floating pin wanders every cycle
  always_ff @(posedge ref_clk_in) float_reg <= !float_reg;
  always_comb begin
    if (!open_in) pin_out = level_in;
    else if (pull_up_en_in) pin_out = 1'b1;
    else if (pull_down_en_in) pin_out = 1'b0;
    else pin_out = float_reg;
  end
endmodule
